//--- sfep_top.sv
//
// Functional notes
// - both erase opcodes act the same
// - erase refused when anything protected; latch cleared
// - erase is opcode only, msb first
// - select release starts self-timed whole erase
// - busy during erase; latch cleared early
// - erase released mid-byte aborts, clears latch
// - suspend ignored during erase
// - program writes one to 256 bytes
// - opcode, three address bytes, data, msb first
// - unsent page bytes stay erased
// - release starts program; byte or page time
// - busy shown in status bit zero
// - program released mid-byte aborts, clears latch
// - protected program not run; latch cleared
// - data past page end wraps within page
// - over 256 bytes keeps last 256
// - short address or data aborts, clears latch
`timescale 1ns/100ps
`include "sfep_params.svh"

module sfep_top
	import sfep_pkg::*;
#(
	parameter int CHIP_ERASE_CYCLES   = `SFEP_CHIP_ERASE_TIME_US * `SFEP_CLK_MHZ,
	parameter int PAGE_PROGRAM_CYCLES = `SFEP_PAGE_PROGRAM_TIME_US * `SFEP_CLK_MHZ,
	parameter int BYTE_PROGRAM_CYCLES = `SFEP_BYTE_PROGRAM_TIME_US * `SFEP_CLK_MHZ
) (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        srst,
	// serial link pins
	input  wire logic        spi_sck,
	input  wire logic        spi_cs_n,
	input  wire logic        spi_si,
	output logic             spi_so,
	output logic             spi_so_oe,
	// protection state
	input  wire logic [2:0]  range_protect_bits,
	input  wire logic        lock_scheme_select,
	input  wire logic        block_lock_any,
	// status
	output logic             busy_flag,
	output logic             write_enable_latch,
	// array write side
	output logic             array_erase_all,
	output logic             array_prog_en,
	output logic [23:0]      array_prog_addr,
	output logic [7:0]       array_prog_data
);

	////////////////////////////////////////////////////////////////////////////
	// elaboration checks: the page walk must finish inside the shortest timer
	if (BYTE_PROGRAM_CYCLES < `SFEP_PAGE_BYTES + 2 || PAGE_PROGRAM_CYCLES < BYTE_PROGRAM_CYCLES
			|| CHIP_ERASE_CYCLES < 1) begin : g_bad_timing
		$error("sfep_top: operation cycle counts too small");
	end

	////////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic is_erase(input logic [7:0] op);
		return (op == `SFEP_OP_ERASE_A) || (op == `SFEP_OP_ERASE_B);
	endfunction

	function automatic logic is_modify(input logic [7:0] op);
		return is_erase(op) || (op == `SFEP_OP_PROGRAM);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// declarations
	logic [2:0]   pins_s;          // synchronised {sck, cs_n, si}
	logic         sck_q_r;         // previous sck
	logic         cs_n_q_r;        // previous cs_n
	logic         sck_rise;        // sample edge within a frame
	logic         sck_fall;        // shift-out edge within a frame
	logic         cs_fall;         // frame start
	logic         cs_rise;         // frame end
	logic [2:0]   bit_cnt_r;       // bit within current byte
	logic [2:0]   byte_cnt_r;      // whole bytes, saturating
	logic [7:0]   shift_r;         // serial input shifter
	logic [7:0]   byte_val;        // completed byte
	logic         byte_done;       // last bit of a byte sampled
	logic [7:0]   opcode_r;        // first byte of frame
	logic [23:0]  addr_r;          // start address
	logic [8:0]   data_cnt_r;      // data bytes sent, top bit sticky
	logic [255:0] valid_r;         // page bytes that were sent
	logic [7:0]   buf_wr_addr;     // wrapped buffer slot
	logic         buf_wr_en;       // store a data byte
	logic [7:0]   buf_rd_data;     // buffer read data
	logic [7:0]   so_shift_r;      // status shift-out
	logic         rd_status;       // frame is a status read
	logic         protected_any;   // some region is protected
	logic         wr_latch_r;      // write enable latch
	sfep_state_t  state_r;         // operation state
	logic [31:0]  timer_r;         // remaining operation cycles
	logic [8:0]   walk_r;          // page walk index
	logic         walk_vld_r;      // read data valid for walk_q_r
	logic [7:0]   walk_q_r;        // slot whose data is arriving
	logic         frame_ok;        // released on a byte boundary
	logic         start_erase;     // launch erase
	logic         start_prog;      // launch program
	logic [7:0]   status_reg_one;  // live status register one

	////////////////////////////////////////////////////////////////////////////
	// pin synchroniser
	sfep_sync #(
		.WIDTH (3)
	) u_sync (
		.clock   (clock),
		.srst    (srst),
		.pin_in  ({spi_sck, spi_cs_n, spi_si}),
		.pin_out (pins_s)
	);

	// edge history
	always_ff @(posedge clock) begin
		if (srst) begin
			sck_q_r  <= 1'b0;
			cs_n_q_r <= 1'b1;
		end else begin
			sck_q_r  <= pins_s[2];
			cs_n_q_r <= pins_s[1];
		end
	end

	assign sck_rise  = pins_s[2] & ~sck_q_r & ~pins_s[1];
	assign sck_fall  = ~pins_s[2] & sck_q_r & ~pins_s[1];
	assign cs_fall   = ~pins_s[1] & cs_n_q_r;
	assign cs_rise   = pins_s[1] & ~cs_n_q_r;
	assign byte_val  = {shift_r[6:0], pins_s[0]};  // msb first
	assign byte_done = sck_rise && (bit_cnt_r == `SFEP_BITS_PER_BYTE);

	////////////////////////////////////////////////////////////////////////////
	// bit and byte counting
	always_ff @(posedge clock) begin
		if (srst || cs_fall) begin
			bit_cnt_r  <= '0;
			byte_cnt_r <= '0;
			shift_r    <= '0;
		end else if (sck_rise) begin
			bit_cnt_r <= bit_cnt_r + 3'h1;
			shift_r   <= byte_val;
			if (bit_cnt_r == `SFEP_BITS_PER_BYTE && byte_cnt_r != 3'h7) begin
				byte_cnt_r <= byte_cnt_r + 3'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// opcode and address capture; frames seen while busy leave the address alone
	always_ff @(posedge clock) begin
		if (srst) begin
			opcode_r <= '0;
			addr_r   <= '0;
		end else if (cs_fall) begin
			opcode_r <= '0;
		end else if (byte_done) begin
			if (byte_cnt_r == 3'h0) begin
				opcode_r <= byte_val;
			end else if (byte_cnt_r <= `SFEP_ADDR_BYTES && state_r == SFEP_IDLE) begin
				addr_r <= {addr_r[15:0], byte_val};  // high byte first
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// data capture into page buffer
	assign buf_wr_addr = addr_r[7:0] + data_cnt_r[7:0];
	assign buf_wr_en   = byte_done && (byte_cnt_r >= `SFEP_FIRST_DATA_BYTE)
		&& (opcode_r == `SFEP_OP_PROGRAM) && (state_r == SFEP_IDLE);

	always_ff @(posedge clock) begin
		// a frame opened while busy must not wipe the slots the walk still reads
		if (srst || (cs_fall && state_r == SFEP_IDLE)) begin
			data_cnt_r <= '0;
			valid_r    <= '0;
		end else if (buf_wr_en) begin
			// later bytes overwrite earlier ones in the same slot
			valid_r[buf_wr_addr] <= 1'b1;
			// low byte wraps with the page, top bit remembers 256 or more
			data_cnt_r <= {data_cnt_r[8] | (&data_cnt_r[7:0]), data_cnt_r[7:0] + 8'h01};
		end
	end

	sfep_page_mem #(
		.DW    (8),
		.DEPTH (`SFEP_PAGE_BYTES)
	) u_page_mem (
		.clock   (clock),
		.srst    (srst),
		.wr_en   (buf_wr_en),
		.wr_addr (buf_wr_addr),
		.wr_data (byte_val),
		.rd_addr (walk_r[7:0]),
		.rd_data (buf_rd_data)
	);

	////////////////////////////////////////////////////////////////////////////
	// frame-end decisions
	assign protected_any = (range_protect_bits != 3'h0) || (lock_scheme_select && block_lock_any);
	assign frame_ok      = cs_rise && (bit_cnt_r == 3'h0) && (state_r == SFEP_IDLE);
	assign start_erase   = frame_ok && is_erase(opcode_r) && (byte_cnt_r == 3'h1)
		&& wr_latch_r && !protected_any;
	assign start_prog    = frame_ok && (opcode_r == `SFEP_OP_PROGRAM)
		&& (byte_cnt_r >= 3'h5) && wr_latch_r && !protected_any;

	// write enable latch
	always_ff @(posedge clock) begin
		if (srst) begin
			wr_latch_r <= 1'b0;
		end else if (cs_rise && state_r == SFEP_IDLE && byte_cnt_r != 3'h0) begin
			if (bit_cnt_r != 3'h0) begin
				// released mid-byte: any modify command is dropped
				if (is_modify(opcode_r)) begin
					wr_latch_r <= 1'b0;
				end
			end else if (opcode_r == `SFEP_OP_WR_ENABLE && byte_cnt_r == 3'h1) begin
				wr_latch_r <= 1'b1;
			end else if (opcode_r == `SFEP_OP_WR_DISABLE && byte_cnt_r == 3'h1) begin
				wr_latch_r <= 1'b0;
			end else if (is_modify(opcode_r)) begin
				// started, refused or malformed: latch drops either way
				wr_latch_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// self-timed operation sequencer
	always_ff @(posedge clock) begin
		if (srst) begin
			state_r <= SFEP_IDLE;
			timer_r <= '0;
		end else begin
			case (state_r)
				SFEP_IDLE: begin
					if (start_erase) begin
						state_r <= SFEP_ERASING;
						timer_r <= 32'(CHIP_ERASE_CYCLES);
					end else if (start_prog) begin
						state_r <= SFEP_PROGRAMMING;
						timer_r <= (data_cnt_r == 9'h001) ? 32'(BYTE_PROGRAM_CYCLES)
							: 32'(PAGE_PROGRAM_CYCLES);
					end
				end
				SFEP_ERASING, SFEP_PROGRAMMING: begin
					// new frames, suspend included, do not disturb the count
					if (timer_r <= 32'h0000_0001) begin
						state_r <= SFEP_IDLE;
						timer_r <= '0;
					end else begin
						timer_r <= timer_r - 32'h0000_0001;
					end
				end
				default: begin
					state_r <= SFEP_IDLE;
					timer_r <= '0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// page walk: read every slot, write only those sent
	always_ff @(posedge clock) begin
		if (srst) begin
			walk_r     <= 9'h100;
			walk_vld_r <= 1'b0;
			walk_q_r   <= '0;
		end else begin
			if (start_prog) begin
				walk_r <= '0;
			end else if (!walk_r[8]) begin
				walk_r <= walk_r + 9'h001;
			end
			walk_vld_r <= !walk_r[8] && !start_prog;
			walk_q_r   <= walk_r[7:0];
		end
	end

	// array write strobe
	always_ff @(posedge clock) begin
		if (srst) begin
			array_prog_en   <= 1'b0;
			array_prog_addr <= '0;
			array_prog_data <= '0;
		end else begin
			array_prog_en   <= walk_vld_r && valid_r[walk_q_r];
			array_prog_addr <= {addr_r[23:8], walk_q_r};
			array_prog_data <= buf_rd_data;
		end
	end

	// one-cycle erase launch
	always_ff @(posedge clock) begin
		if (srst) begin
			array_erase_all <= 1'b0;
		end else begin
			array_erase_all <= start_erase;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// status register one
	assign status_reg_one = {3'h0, range_protect_bits, wr_latch_r, state_r != SFEP_IDLE};

	always_ff @(posedge clock) begin
		if (srst) begin
			busy_flag          <= 1'b0;
			write_enable_latch <= 1'b0;
		end else begin
			busy_flag          <= status_reg_one[`SFEP_STATUS_BUSY];
			write_enable_latch <= status_reg_one[`SFEP_STATUS_LATCH];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// status read out on the serial output, repeats every byte
	assign rd_status = (opcode_r == `SFEP_OP_READ_STATUS) && (byte_cnt_r != 3'h0);

	always_ff @(posedge clock) begin
		if (srst) begin
			so_shift_r <= `SFEP_STATUS_RESET;
			spi_so     <= 1'b0;
			spi_so_oe  <= 1'b0;
		end else begin
			// reload fresh status at each byte boundary
			if (byte_done) begin
				so_shift_r <= status_reg_one;
			end else if (sck_fall && rd_status) begin
				spi_so     <= so_shift_r[7];
				so_shift_r <= {so_shift_r[6:0], 1'b0};
			end
			// drive only while selected in a status read
			if (pins_s[1]) begin
				spi_so_oe <= 1'b0;
			end else if (sck_fall && rd_status) begin
				spi_so_oe <= 1'b1;
			end
		end
	end

endmodule // sfep_top

//--- sfep_params.svh
`ifndef SFEP_PARAMS_SVH
`define SFEP_PARAMS_SVH

// opcodes seen on the serial input
`define SFEP_OP_ERASE_A       8'h60
`define SFEP_OP_ERASE_B       8'hC7
`define SFEP_OP_WR_ENABLE     8'h06
`define SFEP_OP_WR_DISABLE    8'h04
`define SFEP_OP_PROGRAM       8'h02
`define SFEP_OP_READ_STATUS   8'h05

// transfer geometry
`define SFEP_BITS_PER_BYTE    3'h7
`define SFEP_ADDR_BYTES       3'h3
`define SFEP_FIRST_DATA_BYTE  3'h4
`define SFEP_PAGE_BYTES       256

// status register one layout and reset value
`define SFEP_STATUS_BUSY      0
`define SFEP_STATUS_LATCH     1
`define SFEP_STATUS_PROT_LO   2
`define SFEP_STATUS_PROT_HI   4
`define SFEP_STATUS_RESET     8'h00

// self-timed operation times in microseconds, clock in MHz
`define SFEP_CLK_MHZ               25
`define SFEP_CHIP_ERASE_TIME_US    10000
`define SFEP_PAGE_PROGRAM_TIME_US  1000
`define SFEP_BYTE_PROGRAM_TIME_US  100

`endif

//--- sfep_pkg.sv
package sfep_pkg;

	// self-timed operation state
	typedef enum logic [1:0] {
		SFEP_IDLE,
		SFEP_ERASING,
		SFEP_PROGRAMMING
	} sfep_state_t;

endpackage

//--- sfep_sync.sv
`timescale 1ns/100ps

// three-stage pin synchroniser; output follows once stages two and three agree
module sfep_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             srst,
	// asynchronous pins and filtered result
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_out
);

	logic [WIDTH-1:0] stage1_r;  // metastability catcher, read only by stage2
	logic [WIDTH-1:0] stage2_r;  // second stage
	logic [WIDTH-1:0] stage3_r;  // third stage

	////////////////////////////////////////////////////////////////////////////
	// shift chain, left running through reset so it is flushed when reset ends
	always_ff @(posedge clock) begin
		stage1_r <= pin_in;
		stage2_r <= stage1_r;
		stage3_r <= stage2_r;
	end

	////////////////////////////////////////////////////////////////////////////
	// accept a bit only once two stages agree
	always_ff @(posedge clock) begin
		if (srst) begin
			// settle on the pin level so no false edge follows reset
			pin_out <= stage3_r;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (stage2_r[i] == stage3_r[i]) begin
					pin_out[i] <= stage3_r[i];
				end
			end
		end
	end

endmodule // sfep_sync

//--- sfep_page_mem.sv
`timescale 1ns/100ps

// page buffer: one write port, one registered read port
module sfep_page_mem #(
	parameter int DW    = 8,
	parameter int DEPTH = 256,
	parameter int AW    = $clog2(DEPTH)
) (
	// clock and reset
	input  wire logic          clock,
	input  wire logic          srst,
	// write port
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [DW-1:0] wr_data,
	// read port, data one cycle after address
	input  wire logic [AW-1:0] rd_addr,
	output logic      [DW-1:0] rd_data
);

	logic [DW-1:0] mem [DEPTH];  // storage array

	////////////////////////////////////////////////////////////////////////////
	// write
	always_ff @(posedge clock) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// registered read
	always_ff @(posedge clock) begin
		if (srst) begin
			rd_data <= '0;
		end else begin
			rd_data <= mem[rd_addr];
		end
	end

endmodule // sfep_page_mem

//--- sfep_top_sva.sv
`timescale 1ns/100ps

// watches busy timing and the array write side of the sequencer
module sfep_top_sva #(
	parameter int CHIP_ERASE_CYCLES   = 600,
	parameter int PAGE_PROGRAM_CYCLES = 300,
	parameter int BYTE_PROGRAM_CYCLES = 260
) (
	// clock and reset
	input wire logic        clock,
	input wire logic        srst,
	// protection inputs
	input wire logic [2:0]  range_protect_bits,
	input wire logic        lock_scheme_select,
	input wire logic        block_lock_any,
	// serial select and output enable
	input wire logic        spi_cs_n,
	input wire logic        spi_so_oe,
	// status and array outputs
	input wire logic        busy_flag,
	input wire logic        write_enable_latch,
	input wire logic        array_erase_all,
	input wire logic        array_prog_en,
	input wire logic [23:0] array_prog_addr
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);

	int          len_r;  // cycles busy has been high
	logic        er_r;   // current run is an erase
	int          npg_r;  // strobes seen in current run
	logic [7:0]  slot_r; // last strobed slot
	logic [15:0] page_r; // page of the strobes

	// run bookkeeping, cleared as busy falls
	always_ff @(posedge clock) begin
		if (srst) begin
			len_r <= 0;
			er_r <= 1'h0;
			npg_r <= 0;
		end else begin
			len_r <= busy_flag ? len_r + 1 : 0;
			if ($fell(busy_flag)) begin
				er_r <= 1'h0;
				npg_r <= 0;
			end else begin
				if (array_erase_all)
					er_r <= 1'h1;
				if (array_prog_en) begin
					npg_r <= npg_r + 1;
					slot_r <= array_prog_addr[7:0];
					page_r <= array_prog_addr[23:8];
				end
			end
		end
	end

	erase_len_a: assert property ($fell(busy_flag) && er_r |-> len_r == CHIP_ERASE_CYCLES)
		else $error("erase busy time wrong");
	prog_len_a: assert property ($fell(busy_flag) && !er_r |->
		len_r == (npg_r == 1 ? BYTE_PROGRAM_CYCLES : PAGE_PROGRAM_CYCLES))
		else $error("program busy time wrong");
	erase_start_a: assert property (array_erase_all |-> ##[0:1] (busy_flag && !write_enable_latch))
		else $error("erase launch without busy");
	erase_wel_a: assert property (array_erase_all |-> $past(write_enable_latch) || $past(write_enable_latch, 2))
		else $error("erase without latch");
	erase_prot_a: assert property (array_erase_all |->
		range_protect_bits == 3'h0 && !(lock_scheme_select && block_lock_any))
		else $error("erase while protected");
	prog_busy_a: assert property (array_prog_en |-> busy_flag && !array_erase_all)
		else $error("program strobe outside busy");
	slot_order_a: assert property (array_prog_en && npg_r > 0 |-> array_prog_addr[7:0] > slot_r)
		else $error("slots not ascending");
	page_fixed_a: assert property (array_prog_en && npg_r > 0 |-> array_prog_addr[23:8] == page_r)
		else $error("strobe left the page");
	busy_ignore_a: assert property (busy_flag && $past(busy_flag) |->
		!array_erase_all && !$rose(write_enable_latch))
		else $error("command taken while busy");
	oe_idle_a: assert property (spi_cs_n && $past(spi_cs_n, 6) |-> !spi_so_oe)
		else $error("serial output driven while deselected");
endmodule // sfep_top_sva

//--- sfep_host_model.sv
`timescale 1ns/100ps

// spi host: mode 0, msb first, five clocks per sck phase
module sfep_host_model (
	// system clock
	input  wire logic clock,
	// link pins
	output logic      spi_sck,
	output logic      spi_cs_n,
	output logic      spi_si,
	input  wire logic spi_so
);
	initial begin
		spi_sck = 1'h0;
		spi_cs_n = 1'h1;
		spi_si = 1'h0;
	end

	// one frame of whole bytes, then tail bits of ones; rx is the last byte read
	task automatic xfer(input logic [7:0] q[$], input int tail, output logic [7:0] rx);
		int n;
		n = q.size() * 8 + tail;
		rx = 8'h00;
		@(negedge clock) spi_cs_n = 1'h0;
		for (int i = 0; i < n; i++) begin
			spi_si = (i < q.size() * 8) ? q[i / 8][7 - i % 8] : 1'h1;
			repeat (5) @(negedge clock);
			spi_sck = 1'h1;
			rx = {rx[6:0], spi_so};
			repeat (5) @(negedge clock);
			spi_sck = 1'h0;
		end
		repeat (2) @(negedge clock);
		spi_cs_n = 1'h1;
		// released line must not keep showing the last bit
		spi_si = ~spi_si;
		repeat (10) @(negedge clock);
	endtask

	// poll status until the busy bit clears
	task automatic wait_idle(output bit ok);
		logic [7:0] st;
		logic [7:0] q[$];
		q = {8'h05, 8'h00};
		ok = 1'h0;
		for (int k = 0; k < 100 && !ok; k++) begin
			xfer(q, 0, st);
			ok = (st[0] === 1'h0);
		end
	endtask
endmodule // sfep_host_model

//--- tb_top.sv
`timescale 1ns/100ps

module tb_top;
	// clock, reset and design pins
	logic        clock;
	logic        srst;
	logic        spi_sck;
	logic        spi_cs_n;
	logic        spi_si;
	logic        spi_so;
	logic        spi_so_oe;
	logic [2:0]  range_protect_bits;
	logic        lock_scheme_select;
	logic        block_lock_any;
	logic        busy_flag;
	logic        write_enable_latch;
	logic        array_erase_all;
	logic        array_prog_en;
	logic [23:0] array_prog_addr;
	logic [7:0]  array_prog_data;
	// bench state
	int          miscompares;
	int          n_tests;
	int          cyc;
	int          n_er;
	int          n_pg;
	int          n_oe;
	logic [7:0]  got [256];
	bit          got_v [256];
	logic [15:0] got_hi;
	logic [7:0]  q [$];
	logic [7:0]  rx;
	bit          ok;

	// shortened self-timed counts
	sfep_top #(.CHIP_ERASE_CYCLES(600), .PAGE_PROGRAM_CYCLES(300), .BYTE_PROGRAM_CYCLES(260)) dut (
		.clock(clock), .srst(srst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
		.spi_so(spi_so), .spi_so_oe(spi_so_oe), .range_protect_bits(range_protect_bits),
		.lock_scheme_select(lock_scheme_select), .block_lock_any(block_lock_any),
		.busy_flag(busy_flag), .write_enable_latch(write_enable_latch), .array_erase_all(array_erase_all),
		.array_prog_en(array_prog_en), .array_prog_addr(array_prog_addr), .array_prog_data(array_prog_data));
	sfep_host_model host (.clock(clock), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so(spi_so));

	always #20 clock = ~clock;

	// record what the array write side receives, and count serial output enable cycles
	always @(posedge clock) begin
		if (array_erase_all === 1'h1)
			n_er <= n_er + 1;
		if (spi_so_oe === 1'h1)
			n_oe <= n_oe + 1;
		if (array_prog_en === 1'h1) begin
			n_pg <= n_pg + 1;
			got[array_prog_addr[7:0]] <= array_prog_data;
			got_v[array_prog_addr[7:0]] <= 1'h1;
			got_hi <= array_prog_addr[23:8];
		end
	end

	// hang guard
	always @(posedge clock) begin
		cyc = cyc + 1;
		if (cyc == 60000) begin
			miscompares = miscompares + 1;
			print_verdict();
		end
	end

	task automatic print_verdict();
		if (miscompares == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask

	// page slot that data byte i lands in
	function automatic logic [7:0] slot(input logic [23:0] a, input int i);
		return a[7:0] + 8'(i);
	endfunction

	task automatic frame(input logic [7:0] op, input int tail);
		q = {op};
		host.xfer(q, tail, rx);
	endtask

	// latch set, then program n bytes; short address or tail bits break the frame
	task automatic prog(input logic [23:0] a, input int nadr, input int n, input int tail, input bit good);
		logic [7:0] ex[256];
		bit ev[256];
		logic [7:0] d;
		frame(8'h06, 0);
		q = {8'h02};
		for (int i = 0; i < nadr; i++)
			q.push_back(a[23 - 8 * i -: 8]);
		for (int i = 0; i < n; i++) begin
			d = 8'($urandom);
			q.push_back(d);
			ex[slot(a, i)] = d;
			ev[slot(a, i)] = 1'h1;
		end
		n_pg = 0;
		foreach (got_v[s])
			got_v[s] = 1'h0;
		host.xfer(q, tail, rx);
		q = {8'h05, 8'h00};
		n_oe = 0;
		host.xfer(q, 0, rx);
		chk(rx, {3'h0, range_protect_bits, 1'h0, good});
		chk(n_oe != 0, 1'h1);
		host.wait_idle(ok);
		chk(ok, 1'h1);
		chk(n_pg, good ? (n > 256 ? 256 : n) : 0);
		chk(write_enable_latch, 1'h0);
		for (int s = 0; s < 256; s++) begin
			chk(got_v[s], ev[s] && good);
			if (ev[s] && good)
				chk(got[s], ex[s]);
		end
		if (n_pg > 0)
			chk(got_hi, a[23:8]);
	endtask

	initial begin
		int e;
		clock = 1'h0;
		srst = 1'h1;
		range_protect_bits = 3'h0;
		lock_scheme_select = 1'h0;
		block_lock_any = 1'h0;
		{miscompares, n_tests, cyc, n_er, n_pg} = '0;
		void'($urandom(46876));
		repeat (8) @(negedge clock);
		srst = 1'h0;
		repeat (4) @(negedge clock);
		// both erase opcodes; suspend and latch set sent while busy
		for (int k = 0; k < 2; k++) begin
			e = n_er;
			frame(8'h06, 0);
			chk(write_enable_latch, 1'h1);
			frame(k ? 8'hC7 : 8'h60, 0);
			frame(8'h75, 0);
			frame(8'h06, 0);
			chk(write_enable_latch, 1'h0);
			host.wait_idle(ok);
			chk(n_er, e + 1);
		end
		// erase without latch, then erase cut mid-byte
		e = n_er;
		frame(8'h60, 0);
		chk(n_er, e);
		frame(8'h06, 0);
		frame(8'h60, 5);
		chk(n_er, e);
		chk(write_enable_latch, 1'h0);
		// range protection, then block lock
		for (int k = 0; k < 2; k++) begin
			range_protect_bits = k ? 3'h0 : 3'h1 + 3'($urandom % 7);
			lock_scheme_select = 1'(k);
			block_lock_any = 1'(k);
			frame(8'h06, 0);
			frame(8'hC7, 0);
			chk(n_er, e);
			chk(write_enable_latch, 1'h0);
			prog(24'($urandom), 3, 4, 0, 1'h0);
		end
		range_protect_bits = 3'h0;
		lock_scheme_select = 1'h0;
		// a lock counts only with the lock scheme selected, so these must still run
		block_lock_any = 1'h1;
		// program shapes
		prog(24'h00_00FE, 3, 3, 0, 1'h1);
		prog(24'($urandom), 3, 1, 0, 1'h1);
		prog(24'($urandom), 3, 257, 0, 1'h1);
		prog(24'($urandom), 3, 0, 0, 1'h0);
		prog(24'($urandom), 2, 0, 0, 1'h0);
		prog(24'($urandom), 3, 2, 3, 1'h0);
		print_verdict();
	end
endmodule // tb_top

bind sfep_top sfep_top_sva #(
	.CHIP_ERASE_CYCLES(CHIP_ERASE_CYCLES),
	.PAGE_PROGRAM_CYCLES(PAGE_PROGRAM_CYCLES),
	.BYTE_PROGRAM_CYCLES(BYTE_PROGRAM_CYCLES)
) u_sva (
	.clock(clock), .srst(srst), .range_protect_bits(range_protect_bits),
	.lock_scheme_select(lock_scheme_select), .block_lock_any(block_lock_any),
	.busy_flag(busy_flag), .write_enable_latch(write_enable_latch), .array_erase_all(array_erase_all),
	.array_prog_en(array_prog_en), .array_prog_addr(array_prog_addr),
	.spi_cs_n(spi_cs_n), .spi_so_oe(spi_so_oe));
